// File: sim/mdg_gpio_assertions.sv
/*
 Port checker for the dual bank pad controller.
 Assumes it is bound to every mdg_gpio instance, with hready tied to hreadyout.
*/
`timescale 1ns/10ps
module mdg_gpio_assertions (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [25:0] mm_func_out,
   input wire logic [25:0] mm_func_oe,
   input wire logic [25:0] mm_pad_out,
   input wire logic [25:0] mm_pad_oe,
   input wire logic [31:0] mem_func_out,
   input wire logic [31:0] mem_func_oe,
   input wire logic [31:0] mem_pad_out,
   input wire logic [31:0] mem_pad_oe
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic acc;
   logic wr_seen_r;
   logic wr_seen_nxt;
   assign acc = hsel && hready && htrans[1];
   always_comb wr_seen_nxt = wr_seen_r | (acc & hwrite);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) wr_seen_r <= 1'b0;
      else wr_seen_r <= wr_seen_nxt;
   end
   sequence s_wr_addr;
      acc && hwrite;
   endsequence
   sequence s_idle_owner;
      !wr_seen_r && $past(hresetn);
   endsequence
   a_ready_high: assert property (hreadyout) else $error("hreadyout low");
   a_resp_okay: assert property (hresp == mdg_pkg::HRESP_OKAY) else $error("bad hresp");
   a_rdata_stands: assert property (!$past(acc) |-> $stable(hrdata)) else $error("hrdata moved");
   a_wr_zero: assert property (s_wr_addr |=> hrdata == 32'h0) else $error("hrdata on write");
   a_mm_out_owner: assert property (s_idle_owner |-> mm_pad_out == $past(mm_func_out))
      else $error("mm out not owner");
   a_mm_oe_owner: assert property (s_idle_owner |-> mm_pad_oe == $past(mm_func_oe))
      else $error("mm oe not owner");
   a_mem_out_owner: assert property (s_idle_owner |-> mem_pad_out == $past(mem_func_out))
      else $error("mem out not owner");
   a_mem_oe_owner: assert property (s_idle_owner |-> mem_pad_oe == $past(mem_func_oe))
      else $error("mem oe not owner");
endmodule : mdg_gpio_assertions

bind mdg_gpio mdg_gpio_assertions u_chk (.*);

// File: sim/mdg_gpio_tb.sv
/*
 Self-checking bench for the dual bank pad controller.
 Assumes a single AHB-Lite master and zero wait state slave.
*/
`timescale 1ns/10ps
module mdg_gpio_tb;
   // ------------------------------------------------------------
   // Signals, tasks and tests
   // ------------------------------------------------------------
   localparam logic [2:0] SW = mdg_pkg::HSIZE_WORD;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, q, a;
   logic hready, hreadyout, hresp;
   logic [25:0] mm_func_out = 26'h2aaaaaa, mm_func_oe = 26'h1555555, mm_ext = 26'h0f0f0f0;
   logic [25:0] mm_pad_in, mm_pad_out, mm_pad_oe;
   logic [31:0] mem_func_out = 32'h5a5a_5a5a, mem_func_oe = 32'h3c3c_3c3c;
   logic [31:0] mem_ext = 32'hc3a5_9669, mem_pad_in, mem_pad_out, mem_pad_oe;
   int n_mismatch = 0;
   int comparisons = 0;
   assign hready = hreadyout;
   always #20 hclk = ~hclk;
   mdg_gpio DUT (.*);
   mdg_pad_peers u_peers (.*);

   task summarize;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : summarize

   task chk(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task wait_rdy;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask : wait_rdy

   task xfer(input logic w, input logic [2:0] s, input logic [31:0] ad, d,
             output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= ad;
      hwrite <= w;
      hsize <= s;
      htrans <= mdg_pkg::HTRANS_NONSEQ;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask : xfer

   task bank(input logic b, input logic [31:0] m, v, e);
      logic [31:0] k, eo, ee, x;
      k = b ? 32'hffff_ffff : 32'h03ff_ffff;
      x = b ? mem_ext : {6'h0, mm_ext};
      eo = ((m & v) | (~m & (b ? mem_func_out : {6'h0, mm_func_out}))) & k;
      ee = ((m & e) | (~m & (b ? mem_func_oe : {6'h0, mm_func_oe}))) & k;
      xfer(1'b1, SW, b ? 32'h198 : 32'h194, m, q);
      xfer(1'b1, SW, b ? 32'h1ac : 32'h1a0, v, q);
      xfer(1'b1, SW, b ? 32'h1b0 : 32'h1a8, e, q);
      xfer(1'b0, SW, b ? 32'h1ac : 32'h1a0, 32'h0, q);
      chk("value", q, v);
      repeat (6) @(posedge hclk);
      chk("pad out", b ? mem_pad_out : {6'h0, mm_pad_out}, eo);
      chk("pad oe", b ? mem_pad_oe : {6'h0, mm_pad_oe}, ee);
      xfer(1'b0, SW, b ? 32'h1b4 : 32'h1a4, 32'h0, q);
      chk("level", q, ((ee & eo) | (~ee & x)) & k);
      $display("bank test %0d done", b);
   endtask : bank

   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (a = 32'h194; a <= 32'h1b8; a += 4) begin
         xfer(1'b0, SW, a, 32'h0, q);
         if (a != 32'h1a4 && a != 32'h1b4) chk("reset value", q, 32'h0);
      end
      $display("reset test done");
      bank(1'b0, 32'h031f_f00f, 32'hfc5a_a5a5, 32'hffff_00f0);
      bank(1'b1, 32'hffc0_ffc0, 32'h3c3c_a5a5, 32'h0f0f_f0f0);
      bank(1'b0, 32'h0, 32'hffff_ffff, 32'hffff_ffff);
      xfer(1'b1, mdg_pkg::HSIZE_BYTE, 32'h199, 32'h0000_a500, q);
      xfer(1'b1, mdg_pkg::HSIZE_HALF, 32'h19a, 32'h1234_0000, q);
      xfer(1'b0, SW, 32'h198, 32'h0, q);
      chk("narrow write", q, 32'h1234_a5c0);
      xfer(1'b1, SW, 32'h1b8, 32'hffff_ffff, q);
      xfer(1'b0, SW, 32'h1b8, 32'h0, q);
      chk("unmapped", q, 32'h0);
      $display("access size test done");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, SW, 32'h198, 32'h0, q);
      chk("mask after reset", q, 32'h0);
      $display("second reset test done");
      summarize();
   end

   initial begin
      repeat (5000) @(posedge hclk);
      n_mismatch++;
      summarize();
   end
endmodule : mdg_gpio_tb

// File: sim/mdg_pad_peers.sv
/*
 Behavioural peers on the far side of both pad banks.
 Assumes peers drive only where the chip does not drive the pad.
*/
`timescale 1ns/10ps
module mdg_pad_peers (
   input wire logic [25:0] mm_pad_out,
   input wire logic [25:0] mm_pad_oe,
   input wire logic [25:0] mm_ext,
   output logic [25:0] mm_pad_in,
   input wire logic [31:0] mem_pad_out,
   input wire logic [31:0] mem_pad_oe,
   input wire logic [31:0] mem_ext,
   output logic [31:0] mem_pad_in
);
   // ------------------------------------------------------------
   // Wire level: chip where enabled, peer elsewhere
   // ------------------------------------------------------------
   assign mm_pad_in = (mm_pad_oe & mm_pad_out) | (~mm_pad_oe & mm_ext);
   assign mem_pad_in = (mem_pad_oe & mem_pad_out) | (~mem_pad_oe & mem_ext);
endmodule : mdg_pad_peers

// File: verilog/mdg_gpio.sv
/*
 Dual bank masked pad controller with an AHB-Lite register slave.
 Assumes pad inputs are asynchronous and that functional owners supply
 their own value and enable for each pad when the mask bit is clear.
*/
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/10ps
module mdg_gpio (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [25:0] mm_func_out,
   input wire logic [25:0] mm_func_oe,
   input wire logic [25:0] mm_pad_in,
   output logic [25:0] mm_pad_out,
   output logic [25:0] mm_pad_oe,
   input wire logic [31:0] mem_func_out,
   input wire logic [31:0] mem_func_oe,
   input wire logic [31:0] mem_pad_in,
   output logic [31:0] mem_pad_out,
   output logic [31:0] mem_pad_oe
);

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [3:0] mdg_lanes(input logic [2:0] size, input logic [1:0] a);
      logic [3:0] l;
      l = 4'h0;
      case (size)
         mdg_pkg::HSIZE_BYTE: l = 4'h1 << a;
         mdg_pkg::HSIZE_HALF: l = a[1] ? 4'hc : 4'h3;
         default: l = 4'hf;
      endcase
      return l;
   endfunction : mdg_lanes

   function automatic logic [31:0] mdg_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] lanes);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (lanes[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : mdg_merge

   // Masked pad selection: mask set gives register control
   function automatic logic [31:0] mdg_pick(input logic [31:0] mask, input logic [31:0] reg_v,
                                            input logic [31:0] func_v);
      return (mask & reg_v) | (~mask & func_v);
   endfunction : mdg_pick

   // Level settles only where stages two and three agree
   function automatic logic [31:0] mdg_settle(input logic [31:0] s2, input logic [31:0] s3,
                                              input logic [31:0] lvl);
      return (s2 & s3) | (lvl & (s2 | s3));
   endfunction : mdg_settle

   // Zero extension of a multimedia bank vector to a bus word
   function automatic logic [31:0] mdg_widen(input logic [25:0] v);
      return {6'h00, v};
   endfunction : mdg_widen

   // -----------------------------------------------------------------
   // Pad input synchronisers
   // -----------------------------------------------------------------
   logic [25:0] mm_s1_r;
   logic [25:0] mm_s2_r;
   logic [25:0] mm_s3_r;
   logic [25:0] mm_s1_nxt;
   logic [25:0] mm_s2_nxt;
   logic [25:0] mm_s3_nxt;

   // Multimedia chain; stage one feeds stage two only
   always_comb begin
      mm_s1_nxt = mm_pad_in;
      mm_s2_nxt = mm_s1_r;
      mm_s3_nxt = mm_s2_r;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mm_s1_r <= '0;
         mm_s2_r <= '0;
         mm_s3_r <= '0;
      end else begin
         mm_s1_r <= mm_s1_nxt;
         mm_s2_r <= mm_s2_nxt;
         mm_s3_r <= mm_s3_nxt;
      end
   end

   logic [31:0] mem_s1_r;
   logic [31:0] mem_s2_r;
   logic [31:0] mem_s3_r;
   logic [31:0] mem_s1_nxt;
   logic [31:0] mem_s2_nxt;
   logic [31:0] mem_s3_nxt;

   // Memory bank chain; stage one feeds stage two only
   always_comb begin
      mem_s1_nxt = mem_pad_in;
      mem_s2_nxt = mem_s1_r;
      mem_s3_nxt = mem_s2_r;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_s1_r <= '0;
         mem_s2_r <= '0;
         mem_s3_r <= '0;
      end else begin
         mem_s1_r <= mem_s1_nxt;
         mem_s2_r <= mem_s2_nxt;
         mem_s3_r <= mem_s3_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Pad level filter
   // -----------------------------------------------------------------
   logic [25:0] mm_lvl_r;
   logic [25:0] mm_lvl_nxt;
   logic [31:0] mm_lvl_wide;
   logic [31:0] mem_lvl_r;
   logic [31:0] mem_lvl_nxt;

   // Level accepted once stages two and three agree [RULE_06]
   // A pad caught mid transition keeps its old level for a cycle
   always_comb begin
      mm_lvl_wide = mdg_settle(mdg_widen(mm_s2_r), mdg_widen(mm_s3_r), mdg_widen(mm_lvl_r));
      mm_lvl_nxt = mm_lvl_wide[mdg_pkg::MM_PADS-1:0];
      mem_lvl_nxt = mdg_settle(mem_s2_r, mem_s3_r, mem_lvl_r);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mm_lvl_r <= '0;
         mem_lvl_r <= '0;
      end else begin
         mm_lvl_r <= mm_lvl_nxt;
         mem_lvl_r <= mem_lvl_nxt;
      end
   end

   // -----------------------------------------------------------------
   // AHB-Lite slave and register file
   // -----------------------------------------------------------------
   mdg_pkg::mdg_aphase_type ap_r;
   mdg_pkg::mdg_aphase_type ap_nxt;

   // Address phase capture; only accepted phases are marked valid
   always_comb begin
      ap_nxt = ap_r;
      if (hready) begin
         ap_nxt.valid = hsel && (htrans == mdg_pkg::HTRANS_NONSEQ ||
                                 htrans == mdg_pkg::HTRANS_SEQ);
         ap_nxt.write = hwrite;
         ap_nxt.addr = {haddr[mdg_pkg::ADDR_W-1:2], 2'h0};
         ap_nxt.lanes = mdg_lanes(hsize, haddr[1:0]);
      end else begin
         ap_nxt.valid = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_r <= '0;
      end else begin
         ap_r <= ap_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Multimedia bank registers
   // -----------------------------------------------------------------
   mdg_pkg::mdg_bank_type mm_r;
   mdg_pkg::mdg_bank_type mm_nxt;

   // Data phase of a write: byte lanes merged [RULE_14]
   always_comb begin
      mm_nxt = mm_r;
      if (ap_r.valid && ap_r.write) begin
         case (ap_r.addr)
            mdg_pkg::MULTIMEDIA_PAD_MASK_OFS:
               mm_nxt.mask = mdg_merge(mm_r.mask, hwdata, ap_r.lanes); // [RULE_01]
            mdg_pkg::MULTIMEDIA_PAD_OUT_VALUE_OFS:
               mm_nxt.value = mdg_merge(mm_r.value, hwdata, ap_r.lanes); // [RULE_03]
            mdg_pkg::MULTIMEDIA_PAD_DRIVE_ENABLE_OFS:
               mm_nxt.enable = mdg_merge(mm_r.enable, hwdata, ap_r.lanes); // [RULE_04]
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mm_r <= '0; // [RULE_16]
      end else begin
         mm_r <= mm_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Memory bank registers
   // -----------------------------------------------------------------
   mdg_pkg::mdg_bank_type mem_r;
   mdg_pkg::mdg_bank_type mem_nxt;

   // Data phase of a write: byte lanes merged [RULE_14]
   // Writes to the level registers fall to the default and are dropped
   always_comb begin
      mem_nxt = mem_r;
      if (ap_r.valid && ap_r.write) begin
         case (ap_r.addr)
            mdg_pkg::MEMORY_PAD_MASK_OFS:
               mem_nxt.mask = mdg_merge(mem_r.mask, hwdata, ap_r.lanes); // [RULE_02]
            mdg_pkg::MEMORY_PAD_OUT_VALUE_OFS:
               mem_nxt.value = mdg_merge(mem_r.value, hwdata, ap_r.lanes); // [RULE_07]
            mdg_pkg::MEMORY_PAD_DRIVE_ENABLE_OFS:
               mem_nxt.enable = mdg_merge(mem_r.enable, hwdata, ap_r.lanes); // [RULE_05]
            default: ;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_r <= '0; // [RULE_16]
      end else begin
         mem_r <= mem_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Read data
   // -----------------------------------------------------------------
   logic [31:0] hrdata_r;
   logic [31:0] hrdata_nxt;
   logic [31:0] mm_lvl_word;

   assign mm_lvl_word = mdg_widen(mm_lvl_r);

   // Loaded only on an accepted phase, so it stands through the data phase;
   // next register values let a read follow a write to the same word
   always_comb begin
      hrdata_nxt = hrdata_r;
      if (ap_nxt.valid) begin
         hrdata_nxt = mdg_pkg::REG_RESET;
         if (!ap_nxt.write) begin
            case (ap_nxt.addr)
               mdg_pkg::MULTIMEDIA_PAD_MASK_OFS: hrdata_nxt = mm_nxt.mask;
               mdg_pkg::MEMORY_PAD_MASK_OFS: hrdata_nxt = mem_nxt.mask;
               mdg_pkg::MULTIMEDIA_PAD_OUT_VALUE_OFS: hrdata_nxt = mm_nxt.value;
               mdg_pkg::MULTIMEDIA_PAD_LEVEL_OFS: hrdata_nxt = mm_lvl_word; // [RULE_06]
               mdg_pkg::MULTIMEDIA_PAD_DRIVE_ENABLE_OFS: hrdata_nxt = mm_nxt.enable;
               mdg_pkg::MEMORY_PAD_OUT_VALUE_OFS: hrdata_nxt = mem_nxt.value;
               mdg_pkg::MEMORY_PAD_DRIVE_ENABLE_OFS: hrdata_nxt = mem_nxt.enable;
               mdg_pkg::MEMORY_PAD_LEVEL_OFS: hrdata_nxt = mem_lvl_r; // [RULE_06]
               default: hrdata_nxt = mdg_pkg::REG_RESET;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= mdg_pkg::REG_RESET;
      end else begin
         hrdata_r <= hrdata_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Pad drive selection
   // -----------------------------------------------------------------
   logic [31:0] mm_out_w;
   logic [31:0] mm_oe_w;
   logic [25:0] mm_out_r;
   logic [25:0] mm_oe_r;
   logic [25:0] mm_out_nxt;
   logic [25:0] mm_oe_nxt;

   // Bit i maps straight to pad i: 3..0 port, 19..12/20 video, 24/25 panel
   always_comb begin
      mm_out_w = mdg_pick(mm_r.mask, mm_r.value, mdg_widen(mm_func_out)) &
                 mdg_pkg::MM_PAD_FIELD; // [RULE_03] [RULE_08] [RULE_09] [RULE_10] [RULE_15]
      mm_oe_w = mdg_pick(mm_r.mask, mm_r.enable, mdg_widen(mm_func_oe)) &
                mdg_pkg::MM_PAD_FIELD; // [RULE_04] [RULE_05] [RULE_15]
      mm_out_nxt = mm_out_w[mdg_pkg::MM_PADS-1:0];
      mm_oe_nxt = mm_oe_w[mdg_pkg::MM_PADS-1:0];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mm_out_r <= '0;
         mm_oe_r <= '0;
      end else begin
         mm_out_r <= mm_out_nxt;
         mm_oe_r <= mm_oe_nxt;
      end
   end

   logic [31:0] mem_out_r;
   logic [31:0] mem_oe_r;
   logic [31:0] mem_out_nxt;
   logic [31:0] mem_oe_nxt;

   // Bit i maps to memory data line 64+i
   always_comb begin
      mem_out_nxt = mdg_pick(mem_r.mask, mem_r.value, mem_func_out); // [RULE_07] [RULE_11]
      mem_oe_nxt = mdg_pick(mem_r.mask, mem_r.enable, mem_func_oe); // [RULE_12] [RULE_13] [RULE_15]
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_out_r <= '0;
         mem_oe_r <= '0;
      end else begin
         mem_out_r <= mem_out_nxt;
         mem_oe_r <= mem_oe_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Bus response
   // -----------------------------------------------------------------
   logic hreadyout_r;
   logic hreadyout_nxt;
   logic hresp_r;
   logic hresp_nxt;

   // Zero wait states; every transfer ends OKAY, ready even in reset
   always_comb begin
      hreadyout_nxt = 1'b1;
      hresp_nxt = mdg_pkg::HRESP_OKAY;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_r <= 1'b1;
         hresp_r <= mdg_pkg::HRESP_OKAY;
      end else begin
         hreadyout_r <= hreadyout_nxt;
         hresp_r <= hresp_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign hrdata = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;
   assign mm_pad_out = mm_out_r;
   assign mm_pad_oe = mm_oe_r;
   assign mem_pad_out = mem_out_r;
   assign mem_pad_oe = mem_oe_r;

endmodule : mdg_gpio

// File: verilog/mdg_pkg.sv
/*
 Constants, register map and carrier types for the dual bank pad controller.
 Assumes an AHB-Lite master on a single 25 MHz clock domain.
*/
//
// Behaviour
// RULE_01 - Multimedia mask gates value and enable bits
// RULE_02 - Memory mask gates value and enable bits
// RULE_03 - Multimedia value register drives 26 pads
// RULE_04 - Multimedia enable register sets 26 pad directions
// RULE_05 - Effective enable one drives, zero inputs
// RULE_06 - Level registers read sensed pad levels
// RULE_07 - Memory value register drives shared pads
// RULE_08 - Multimedia bits 3..0 are peripheral address/data
// RULE_09 - Bits 19..12 video data, 20 clock
// RULE_10 - Bits 24, 25 panel clock and enable
// RULE_11 - Memory bits 15..8 are data lines 79..72
// RULE_12 - Memory bits 22, 23 are lines 86, 87
// RULE_13 - Bits 31..24 lines 95..88; 7..6 lines 71..70
// RULE_14 - Registers accept 8, 16, 32 bit accesses
// RULE_15 - Clear mask leaves pad with functional owner
// RULE_16 - Mask, value, enable registers reset to zero
package mdg_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [11:0] MULTIMEDIA_PAD_MASK_OFS = 12'h194;
   localparam logic [11:0] MEMORY_PAD_MASK_OFS = 12'h198;
   localparam logic [11:0] MULTIMEDIA_PAD_OUT_VALUE_OFS = 12'h1a0;
   localparam logic [11:0] MULTIMEDIA_PAD_LEVEL_OFS = 12'h1a4;
   localparam logic [11:0] MULTIMEDIA_PAD_DRIVE_ENABLE_OFS = 12'h1a8;
   localparam logic [11:0] MEMORY_PAD_OUT_VALUE_OFS = 12'h1ac;
   localparam logic [11:0] MEMORY_PAD_DRIVE_ENABLE_OFS = 12'h1b0;
   localparam logic [11:0] MEMORY_PAD_LEVEL_OFS = 12'h1b4;
   localparam int ADDR_W = 12;

   // -----------------------------------------------------------------
   // Widths and reset values
   // -----------------------------------------------------------------
   localparam int MM_PADS = 26;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [31:0] MM_PAD_FIELD = 32'h03ff_ffff;

   // -----------------------------------------------------------------
   // AHB encodings
   // -----------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic [2:0] HSIZE_BYTE = 3'h0;
   localparam logic [2:0] HSIZE_HALF = 3'h1;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // Latched address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [3:0] lanes;
   } mdg_aphase_type;

   // One bank of pad controls
   typedef struct packed {
      logic [31:0] mask;
      logic [31:0] value;
      logic [31:0] enable;
   } mdg_bank_type;

endpackage : mdg_pkg
